// ### dv/fpe_ctrl_tb_top.sv
/* Self-checking bench for the flash program/erase controller.
   Assumes the flash model below answers on the byte bus. */
`timescale 1ns/1ps
`default_nettype none
module fpe_ctrl_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [7:0] awa = 8'h0, ara = 8'h0, prot = 8'hff, mrd;
  logic [31:0] wd = 32'h0, rdat;
  logic awr, wrdy, bv, ardy, rv;
  logic [1:0] bresp, rresp;
  fpe_pkg::fpe_mem_s mem;
  int miscompares = 0, cmp_count = 0, cyc = 0, hv_exp = 0;
  logic [16:0] rnd = 17'h1252b;
  logic [7:0] eb [32];
  always #50 clk = ~clk;
  fpe_ctrl #(.ERS_SHORT_CYC(20), .ERS_LONG_CYC(20), .MASS_CYC(20)) u_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_axi_awvalid(awv),
    .o_axi_awready(awr), .i_axi_awaddr(awa), .i_axi_wvalid(wv),
    .o_axi_wready(wrdy), .i_axi_wdata(wd), .i_axi_wstrb(4'hf),
    .o_axi_bvalid(bv), .i_axi_bready(bready), .o_axi_bresp(bresp),
    .i_axi_arvalid(arv), .o_axi_arready(ardy), .i_axi_araddr(ara),
    .o_axi_rvalid(rv), .i_axi_rready(rready), .o_axi_rdata(rdat),
    .o_axi_rresp(rresp), .o_mem(mem), .i_mem_rdata(mrd));
  fpe_flash_model u_flash (.i_clk_sys(clk), .i_mem(mem), .i_prot(prot),
    .o_rdata(mrd));
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= d;
    @(posedge clk iff (awr && wrdy));
    awv <= 1'b0;
    wv <= 1'b0;
    bready <= 1'b1;
    @(posedge clk iff bv);
    chk(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    @(posedge clk iff ardy);
    arv <= 1'b0;
    rready <= 1'b1;
    @(posedge clk iff rv);
    d = rdat;
    r = rresp;
    rready <= 1'b0;
  endtask
  // Starts one operation, polls busy, then clears the sticky flags
  task automatic run(input logic [31:0] c, input logic [15:0] a,
                     input logic e, output logic [31:0] s);
    logic [1:0] r;
    wr(8'h04, {16'h0, a}, 2'h0);
    wr(8'h00, c | 32'h8000_0000, 2'h0);
    do rd(8'h08, s, r); while (s[0] !== 1'b0);
    chk(32'(s[2:1]), {30'h0, e, 1'b1});
    if (!e) hv_exp++;
    chk(u_flash.hv_cnt, hv_exp);
    wr(8'h08, 32'h6, 2'h0);
  endtask
  task automatic prog_row(input logic [15:0] row, input logic [4:0] o);
    logic [31:0] s;
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      eb[i] = rnd[7:0];
    end
    for (int k = 0; k < 8; k++)
      wr(8'(8'h20 + 4 * k), {eb[4*k+3], eb[4*k+2], eb[4*k+1], eb[4*k]},
         2'h0);
    for (int i = 0; i < 32; i++)
      chk(32'(u_flash.arr[row[13:0] + i]), 32'hff);
    run({18'h0, 6'(32 - o), 8'h03}, row + 16'(o), 1'b0, s);
    chk(32'(s[15:8]), 32'(prot));
    for (int i = 0; i < 32; i++)
      chk(32'(u_flash.arr[row[13:0] + i]),
          32'(i >= o ? eb[i] : 8'hff));
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    logic [31:0] s;
    logic [1:0] r;
    logic [15:0] row;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h08, s, r);
    chk(s, 32'h0);
    rd(8'h44, s, r);
    chk(32'(r), 32'h2);
    wr(8'h44, 32'h1, 2'h2);
    run(32'h0000_2000, 16'hc000, 1'b1, s);
    run(32'h0000_2003, 16'hc001, 1'b1, s);
    for (int l = 0; l < 2; l++) begin
      rnd = lfsr(rnd);
      row = 16'hc000 + {3'h0, rnd[12:5], 5'h0};
      prog_row(row, l == 0 ? 5'h0 : rnd[4:0]);
      run({29'h0, l[0], 2'h1}, row ^ 16'h0020, 1'b0, s);
      for (int i = 0; i < 64; i++)
        chk(32'(u_flash.arr[{row[13:6], 6'h0} + i]), 32'hff);
    end
    prot <= 8'hfe;
    run(32'h1, 16'hff80, 1'b1, s);
    chk(32'(s[15:8]), 32'hfe);
    run(32'h1, 16'hff40, 1'b0, s);
    run(32'h2, 16'hc000, 1'b1, s);
    prot <= 8'h00;
    run(32'h0000_2003, 16'hc000, 1'b1, s);
    prot <= 8'hff;
    prog_row(16'hc040, 5'h0);
    run(32'ha, 16'hc040, 1'b0, s);
    for (int i = 0; i < 32; i++)
      chk(32'(u_flash.arr[14'h0040 + i]), 32'hff);
    chk(u_flash.faults, 0);
    complete_run;
  end
endmodule
`default_nettype wire

// ### dv/fpe_flash_model.sv
/* Behavioural flash array with its control register on the byte bus.
   Assumes we/re pulse for one cycle and that the address is held. */
`timescale 1ns/1ps
`default_nettype none
module fpe_flash_model (
  input  wire logic              i_clk_sys,
  input  wire fpe_pkg::fpe_mem_s i_mem,
  input  wire logic [7:0]        i_prot,
  output logic [7:0]             o_rdata
);
  logic [7:0]  arr [16384];
  logic [3:0]  ctl;
  logic        armed;
  logic        prd;
  logic        ok;
  logic [3:0]  n;
  logic [15:0] arm_a;
  int          faults;
  int          hv_cnt;
  initial begin
    foreach (arr[i]) arr[i] = 8'hff;
    ctl = 4'h0;
    armed = 1'b0;
    prd = 1'b0;
    arm_a = 16'h0;
    faults = 0;
    hv_cnt = 0;
  end
  assign o_rdata = (i_mem.addr == 16'hfe08) ? {4'h0, ctl} :
                   (i_mem.addr == 16'hff7e) ? i_prot : arr[i_mem.addr[13:0]];
  always @(posedge i_clk_sys) begin
    if (i_mem.re && i_mem.addr == 16'hff7e && ctl[1:0] != 2'h0)
      prd = 1'b1;
    if (i_mem.we && i_mem.addr == 16'hfe08) begin
      n = i_mem.wdata[3:0];
      // Protected range starts at 11, byte, 000000
      ok = i_prot == 8'hff ||
           (!n[2] && arm_a < {2'b11, i_prot, 6'h0});
      if (n[1] && n[0]) begin
        faults++;
      end else if (n[3] && !ctl[3] &&
                   !(n[1:0] != 2'h0 && armed && prd && ok)) begin
        faults++;
      end else begin
        if (ctl[3] && ctl[1] && !n[1]) begin
          // Erase lands when the select drops under high voltage
          if (ctl[2]) foreach (arr[i]) arr[i] = 8'hff;
          else for (int i = 0; i < 64; i++)
            arr[{arm_a[13:6], i[5:0]}] = 8'hff;
        end
        if (n[3] && !ctl[3]) hv_cnt++;
        if (n[1:0] == 2'h0 && !n[3]) begin
          armed = 1'b0;
          prd = 1'b0;
        end
        ctl = n;
      end
    end else if (i_mem.we && ctl[3] && ctl[0]) begin
      if (i_mem.addr[15:5] != arm_a[15:5]) faults++;
      else arr[i_mem.addr[13:0]] &= i_mem.wdata;
    end else if (i_mem.we && ctl[1:0] != 2'h0 && !armed) begin
      armed = 1'b1;
      arm_a = i_mem.addr;
    end
  end
endmodule
`default_nettype wire

// ### logic/fpe_ctrl.sv
/*
 * Host-side controller that runs page erase, whole-array erase and row
 * programming on an embedded flash through its byte-wide memory bus.
 * Assumes the flash answers a read on i_mem_rdata while o_mem holds the
 * address, and that software reaches the controller over AXI4-Lite.
 */
// Behaviour
// - Page erase: select erase, read protection, write inside page.
// - Page erase waits setup, erase time, hold, then drops voltage.
// - Prefer the 4 ms erase time for long-lived locations.
// - Mass erase: select both, read protection, arm, wait, 4 ms.
// - End mass erase by clearing selects, wait 100 us, drop voltage.
// - Wait recovery time after dropping voltage before reading.
// - Program: select, read protection, arm, voltage, timed bytes.
// - Only bytes reading all ones may be programmed; the code writes each byte without reading it first.
// - Summed high-voltage time per row stays within its limit.
// - Gaps between byte writes stay under the byte program maximum.
// - Steps run from outside the array, in the listed order.
// - Interrupts stay disabled during any sequence.
// - In failed-security monitor mode arm at the protection byte; the code does so for erase only, a program arms at its own address.
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defs.svh"
module fpe_ctrl #(
  parameter int ERS_SHORT_CYC = `FPE_T_ERS_SHORT_US * `FPE_CLK_MHZ,
  parameter int ERS_LONG_CYC  = `FPE_T_ERS_LONG_US * `FPE_CLK_MHZ,
  parameter int MASS_CYC      = `FPE_T_MASS_US * `FPE_CLK_MHZ
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic         i_axi_awvalid,
  output logic              o_axi_awready,
  input  wire logic [7:0]   i_axi_awaddr,
  input  wire logic         i_axi_wvalid,
  output logic              o_axi_wready,
  input  wire logic [31:0]  i_axi_wdata,
  input  wire logic [3:0]   i_axi_wstrb,
  output logic              o_axi_bvalid,
  input  wire logic         i_axi_bready,
  output logic [1:0]        o_axi_bresp,
  input  wire logic         i_axi_arvalid,
  output logic              o_axi_arready,
  input  wire logic [7:0]   i_axi_araddr,
  output logic              o_axi_rvalid,
  input  wire logic         i_axi_rready,
  output logic [31:0]       o_axi_rdata,
  output logic [1:0]        o_axi_rresp,
  output fpe_pkg::fpe_mem_s o_mem,
  input  wire logic [7:0]   i_mem_rdata
);
  localparam int NVS_CYC  = `FPE_T_NVS_US * `FPE_CLK_MHZ;
  localparam int PGS_CYC  = `FPE_T_PGS_US * `FPE_CLK_MHZ;
  localparam int NVH_CYC  = `FPE_T_NVH_US * `FPE_CLK_MHZ;
  localparam int NVHL_CYC = `FPE_T_NVHL_US * `FPE_CLK_MHZ;
  localparam int PROG_CYC = `FPE_T_PROG_US * `FPE_CLK_MHZ;
  localparam int RCV_CYC  = `FPE_T_RCV_US * `FPE_CLK_MHZ;
  localparam logic [7:0] HV_M = 8'h01 << `FPE_HV_BIT;
  localparam logic [7:0] MS_M = 8'h01 << `FPE_MASS_BIT;
  localparam logic [7:0] ER_M = 8'h01 << `FPE_ERASE_BIT;
  localparam logic [7:0] PG_M = 8'h01 << `FPE_PGM_BIT;

  fpe_pkg::fpe_state_s q;
  fpe_pkg::fpe_state_s d;
  logic       wr;
  logic       rd;
  logic       go;
  logic       bad;
  logic [6:0] span;
  logic [7:0] sel;

  assign wr = i_axi_awvalid & i_axi_wvalid & ~q.bvalid;
  assign rd = i_axi_arvalid & ~q.rvalid;
  assign o_axi_awready = wr;
  assign o_axi_wready  = wr;
  assign o_axi_arready = ~q.rvalid;
  assign o_axi_bvalid  = q.bvalid;
  assign o_axi_bresp   = {q.bslverr, 1'b0};
  assign o_axi_rvalid  = q.rvalid;
  assign o_axi_rdata   = q.rdata;
  assign o_axi_rresp   = {q.rslverr, 1'b0};
  assign o_mem         = q.mem;

  // Program and erase selects are never driven together; mass erase adds its own select to erase
  assign sel = (q.op == fpe_pkg::FPE_OP_PROG) ? PG_M :
               (q.op == fpe_pkg::FPE_OP_MASS) ? (ER_M | MS_M) : ER_M;

  always_comb begin
    d = q;
    go = 1'b0;
    d.mem.we = 1'b0;
    d.mem.re = 1'b0;
    d.sync1 = i_mem_rdata;
    d.sync2 = q.sync1;
    if (q.bvalid && i_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && i_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (wr) begin
      d.bvalid = 1'b1;
      d.bslverr = 1'b0;
      // Control words need every lane; a partial write is dropped
      if (i_axi_awaddr == `FPE_AX_CTRL) begin
        if (!q.busy && i_axi_wstrb == 4'hf) begin
          d.op  = fpe_pkg::fpe_op_e'(i_axi_wdata[1:0]);
          d.lng = i_axi_wdata[`FPE_CTRL_LONG];
          d.mon = i_axi_wdata[`FPE_CTRL_MON];
          d.cnt = i_axi_wdata[13:8];
          go    = i_axi_wdata[`FPE_CTRL_START];
        end
      end else if (i_axi_awaddr == `FPE_AX_ADDR) begin
        if (!q.busy && i_axi_wstrb == 4'hf) begin
          d.addr = i_axi_wdata[15:0];
        end
      end else if (i_axi_awaddr == `FPE_AX_STAT) begin
        if (i_axi_wdata[`FPE_STAT_DONE] && i_axi_wstrb[0]) begin
          d.done = 1'b0;
        end
        if (i_axi_wdata[`FPE_STAT_ERR] && i_axi_wstrb[0]) begin
          d.err = 1'b0;
        end
      end else if (i_axi_awaddr[7:5] == `FPE_AX_BUF) begin
        for (int i = 0; i < 4; i++) begin
          if (i_axi_wstrb[i]) begin
            d.buffer[{i_axi_awaddr[4:2], 2'(i)}] = i_axi_wdata[8*i +: 8];
          end
        end
      end else begin
        d.bslverr = 1'b1;
      end
    end
    if (rd) begin
      d.rvalid = 1'b1;
      d.rslverr = 1'b0;
      d.rdata = 32'h0000_0000;
      if (i_axi_araddr == `FPE_AX_CTRL) begin
        d.rdata[13:0] = {q.cnt, 4'h0, q.mon, q.lng, q.op};
      end else if (i_axi_araddr == `FPE_AX_ADDR) begin
        d.rdata[15:0] = q.addr;
      end else if (i_axi_araddr == `FPE_AX_STAT) begin
        d.rdata[15:0] = {q.prot, 5'h00, q.err, q.done, q.busy};
      end else if (i_axi_araddr[7:5] == `FPE_AX_BUF) begin
        for (int i = 0; i < 4; i++) begin
          d.rdata[8*i +: 8] = q.buffer[{i_axi_araddr[4:2], 2'(i)}];
        end
      end else begin
        d.rslverr = 1'b1;
      end
    end
    // A row program may not leave its 32-byte row
    span = {2'h0, d.addr[4:0]} + {1'b0, d.cnt};
    bad = (d.op == fpe_pkg::FPE_OP_NONE) ||
          ((d.op == fpe_pkg::FPE_OP_PROG) &&
           (d.cnt == 6'h00 || span > {1'b0, `FPE_ROW_BYTES}));
    unique case (q.st)
      fpe_pkg::S_IDLE: begin
        if (go) begin
          d.err = bad;
          d.done = bad;
          d.busy = ~bad;
          d.idx = 6'h00;
          if (!bad) begin
            d.st = fpe_pkg::S_SEL;
          end
        end
      end
      fpe_pkg::S_SEL: begin
        d.mem = '{`FPE_DEV_CTRL, sel, 1'b1, 1'b0};
        d.st = fpe_pkg::S_RDP;
      end
      fpe_pkg::S_RDP: begin
        d.mem = '{`FPE_DEV_PROT, 8'h00, 1'b0, 1'b1};
        d.tmr = `FPE_RD_WAIT;
        d.st = fpe_pkg::S_RDW;
      end
      fpe_pkg::S_RDW: begin
        if (q.tmr != 17'h00000) begin
          d.tmr = q.tmr - 17'h00001;
        end else begin
          d.prot = q.sync2;
          // Abort early rather than let the device refuse high voltage
          if (q.sync2 != 8'hff && (q.op == fpe_pkg::FPE_OP_MASS ||
              q.addr[15:6] >= {2'b11, q.sync2})) begin
            d.err = 1'b1;
            d.mem = '{`FPE_DEV_CTRL, 8'h00, 1'b1, 1'b0};
            d.st = fpe_pkg::S_DONE;
          end else begin
            d.prot_ok = 1'b1;
            d.st = fpe_pkg::S_ARM;
          end
        end
      end
      fpe_pkg::S_ARM: begin
        d.mem = '{(q.mon && q.op != fpe_pkg::FPE_OP_PROG) ?
                  `FPE_DEV_PROT : q.addr, 8'hff, 1'b1, 1'b0};
        d.st = fpe_pkg::S_WAIT;
        d.nxt = fpe_pkg::S_HVON;
        d.tmr = 17'(NVS_CYC - 1);
      end
      fpe_pkg::S_HVON: begin
        d.mem = '{`FPE_DEV_CTRL, sel | HV_M, 1'b1, 1'b0};
        d.st = fpe_pkg::S_WAIT;
        if (q.op == fpe_pkg::FPE_OP_PROG) begin
          d.nxt = fpe_pkg::S_PWR;
          d.tmr = 17'(PGS_CYC - 1);
        end else begin
          d.nxt = fpe_pkg::S_CLRS;
          d.tmr = (q.op == fpe_pkg::FPE_OP_MASS) ? 17'(MASS_CYC - 1) :
                  q.lng ? 17'(ERS_LONG_CYC - 1) :
                  17'(ERS_SHORT_CYC - 1);
        end
      end
      fpe_pkg::S_PWR: begin
        d.mem = '{q.addr + {10'h000, q.idx},
                  q.buffer[5'(q.addr[4:0] + q.idx[4:0])], 1'b1, 1'b0};
        d.idx = q.idx + 6'h01;
        d.st = fpe_pkg::S_WAIT;
        d.tmr = 17'(PROG_CYC - 1);
        d.nxt = (q.idx + 6'h01 == q.cnt) ? fpe_pkg::S_CLRS :
                fpe_pkg::S_PWR;
      end
      fpe_pkg::S_CLRS: begin
        d.mem = '{`FPE_DEV_CTRL, HV_M, 1'b1, 1'b0};
        d.st = fpe_pkg::S_WAIT;
        d.nxt = fpe_pkg::S_HVOFF;
        d.tmr = (q.op == fpe_pkg::FPE_OP_MASS) ? 17'(NVHL_CYC - 1) :
                17'(NVH_CYC - 1);
      end
      fpe_pkg::S_HVOFF: begin
        d.mem = '{`FPE_DEV_CTRL, 8'h00, 1'b1, 1'b0};
        d.st = fpe_pkg::S_WAIT;
        d.nxt = fpe_pkg::S_DONE;
        d.tmr = 17'(RCV_CYC - 1);
      end
      fpe_pkg::S_WAIT: begin
        if (q.tmr == 17'h00000) begin
          d.st = q.nxt;
        end else begin
          d.tmr = q.tmr - 17'h00001;
        end
      end
      fpe_pkg::S_DONE: begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.prot_ok = 1'b0;
        d.st = fpe_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.st <= fpe_pkg::S_IDLE;
      q.nxt <= fpe_pkg::S_IDLE;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  property p_hv_after_prot;
    (q.mem.we && q.mem.addr == `FPE_DEV_CTRL && q.mem.wdata[`FPE_HV_BIT]
     && q.mem.wdata != HV_M) |-> q.prot_ok;
  endproperty
  a_hv_after_prot: assert property (p_hv_after_prot)
    else $error("high voltage set before protection read");
  property p_erase_hold;
    (q.st == fpe_pkg::S_HVON && q.op == fpe_pkg::FPE_OP_PAGE) |=>
      (q.tmr == (q.lng ? 17'(ERS_LONG_CYC - 1) : 17'(ERS_SHORT_CYC - 1)));
  endproperty
  a_erase_hold: assert property (p_erase_hold)
    else $error("page erase hold time wrong");
  property p_mass_hold;
    (q.st == fpe_pkg::S_HVON && q.op == fpe_pkg::FPE_OP_MASS) |=>
      (q.st == fpe_pkg::S_WAIT && q.tmr == 17'(MASS_CYC - 1));
  endproperty
  a_mass_hold: assert property (p_mass_hold)
    else $error("mass erase hold time wrong");
  property p_mass_nvhl;
    (q.st == fpe_pkg::S_CLRS && q.op == fpe_pkg::FPE_OP_MASS) |=>
      (q.tmr == 17'(NVHL_CYC - 1) && q.mem.wdata == HV_M);
  endproperty
  a_mass_nvhl: assert property (p_mass_nvhl)
    else $error("mass erase release wait wrong");
  property p_recovery;
    (q.st == fpe_pkg::S_HVOFF) |=>
      (q.st == fpe_pkg::S_WAIT)[*8] ##3 (q.st == fpe_pkg::S_DONE);
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("recovery wait not ten cycles");
  property p_arm_setup;
    (q.st == fpe_pkg::S_ARM) |=> (q.mem.we && q.tmr == 17'(NVS_CYC - 1)
      && $past(q.prot_ok));
  endproperty
  a_arm_setup: assert property (p_arm_setup)
    else $error("arm setup wrong");
  property p_clr_sel;
    (q.st == fpe_pkg::S_CLRS) |=> (q.mem.we && q.mem.wdata == HV_M
      && q.mem.addr == `FPE_DEV_CTRL);
  endproperty
  a_clr_sel: assert property (p_clr_sel)
    else $error("select not cleared with voltage held");
  property p_row_stay;
    (q.st == fpe_pkg::S_PWR) |=> (q.mem.addr[15:5] == q.addr[15:5]
      && q.tmr == 17'(PROG_CYC - 1));
  endproperty
  a_row_stay: assert property (p_row_stay)
    else $error("byte write left the row or wrong gap");
  c_page: cover property (q.st == fpe_pkg::S_DONE &&
                          q.op == fpe_pkg::FPE_OP_PAGE && !q.err);
  c_mass: cover property (q.st == fpe_pkg::S_DONE &&
                          q.op == fpe_pkg::FPE_OP_MASS && !q.err);
  c_prog: cover property (q.st == fpe_pkg::S_DONE &&
                          q.op == fpe_pkg::FPE_OP_PROG && q.idx > 6'h01);
  c_prot: cover property (q.st == fpe_pkg::S_DONE && q.prot_ok == 1'b0
                          && q.err);
endmodule
`default_nettype wire

// ### shared/fpe_defs.svh
/*
 * Constants for the flash program/erase controller: device addresses,
 * control bit positions, timing figures, and the host register map.
 * Assumes a 10 MHz system clock.
 */
`ifndef FPE_DEFS_SVH
`define FPE_DEFS_SVH
`define FPE_CLK_MHZ 10
`define FPE_DEV_CTRL 16'hfe08
`define FPE_DEV_PROT 16'hff7e
`define FPE_HV_BIT 3
`define FPE_MASS_BIT 2
`define FPE_ERASE_BIT 1
`define FPE_PGM_BIT 0
`define FPE_T_NVS_US 10
`define FPE_T_PGS_US 5
`define FPE_T_NVH_US 5
`define FPE_T_NVHL_US 100
`define FPE_T_PROG_US 30
`define FPE_T_RCV_US 1
`define FPE_T_ERS_SHORT_US 1000
`define FPE_T_ERS_LONG_US 4000
`define FPE_T_MASS_US 4000
`define FPE_RD_WAIT 17'h00003
`define FPE_ROW_BYTES 6'h20
`define FPE_AX_CTRL 8'h00
`define FPE_AX_ADDR 8'h04
`define FPE_AX_STAT 8'h08
`define FPE_AX_BUF 3'h1
`define FPE_CTRL_LONG 2
`define FPE_CTRL_MON 3
`define FPE_CTRL_START 31
`define FPE_STAT_DONE 1
`define FPE_STAT_ERR 2
`endif

// ### shared/fpe_pkg.sv
/*
 * Types of the flash program/erase controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpe_pkg;
  typedef enum logic [1:0] {
    FPE_OP_NONE = 2'h0,
    FPE_OP_PAGE = 2'h1,
    FPE_OP_MASS = 2'h2,
    FPE_OP_PROG = 2'h3
  } fpe_op_e;
  typedef enum logic [10:0] {
    S_IDLE  = 11'h001,
    S_SEL   = 11'h002,
    S_RDP   = 11'h004,
    S_RDW   = 11'h008,
    S_ARM   = 11'h010,
    S_HVON  = 11'h020,
    S_PWR   = 11'h040,
    S_CLRS  = 11'h080,
    S_HVOFF = 11'h100,
    S_WAIT  = 11'h200,
    S_DONE  = 11'h400
  } fpe_st_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } fpe_mem_s;
  typedef struct packed {
    fpe_st_e         st;
    fpe_st_e         nxt;
    logic [16:0]     tmr;
    fpe_op_e         op;
    logic            lng;
    logic            mon;
    logic [5:0]      cnt;
    logic [5:0]      idx;
    logic [15:0]     addr;
    logic [7:0]      prot;
    logic            prot_ok;
    logic            busy;
    logic            done;
    logic            err;
    logic [7:0]      sync1;
    logic [7:0]      sync2;
    fpe_mem_s        mem;
    logic            bvalid;
    logic            bslverr;
    logic            rvalid;
    logic            rslverr;
    logic [31:0]     rdata;
    logic [31:0][7:0] buffer;
  } fpe_state_s;
endpackage
